// *** design/rsd_pkg.sv ***
package rsd_pkg;
    // Register addresses on the serial host's register port
    localparam logic [7:0] LDO_TWO_CONTROL_ADDR = 8'h28;
    localparam logic [7:0] LDO_THREE_CONTROL_ADDR = 8'h29;
    localparam logic [7:0] DISCHARGE_CONTROL_ONE_ADDR = 8'h40;
    localparam logic [7:0] DISCHARGE_CONTROL_TWO_ADDR = 8'h41;

    // LDO control layout
    localparam int SLEEP_SEL_LSB = 4;
    localparam int RSVD_LSB = 1;
    localparam int SOFT_EN_BIT = 0;
    localparam logic [7:0] LDO_CTRL_WMASK = 8'h3f;
    localparam logic [1:0] SLEEP_OFF = 2'h0;
    localparam logic [1:0] SLEEP_ON = 2'h3;
    localparam logic [2:0] RSVD_RESET = 3'h6;

    // Discharge codes
    localparam logic [1:0] DISCH_NONE = 2'h0;
    localparam logic [1:0] DISCH_100_OHM = 2'h1;
    localparam logic [1:0] DISCH_200_OHM = 2'h2;
    localparam logic [1:0] DISCH_500_OHM = 2'h3;
    localparam int NUM_DISCH_RAILS = 8;

    // Sleep pin choice, fixed at the factory
    localparam logic SLEEP_PIN_ONE = 1'b0;
    localparam logic SLEEP_PIN_TWO = 1'b1;

    // Register write request
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsd_req_s;

    // Host-visible register state and read data
    typedef struct packed {
        logic [7:0] ldo_two_ctrl;
        logic [7:0] ldo_three_ctrl;
        logic [15:0] disch;
        logic [7:0] rdata;
    } rsd_state_s;
endpackage

// *** design/rsd_regs.sv ***
// Behaviour
// - Sleep select 00 always uses normal code
// - Select 11 uses sleep code while pin low
// - Sleep pin is a fixed factory choice
// - Soft enable bit 0 low forces rail off
// - Register 29h mirrors layout and behaviour
// - Register 29h bits 7:6 read zero, read-only
// - Discharge code selects none/100/200/500 ohms
// - Enabled rail clears its discharge code
// - Register 40h holds buck four..one codes
// - Register 41h holds ldo two, switch, bucks
// - Register 28h bits 7:6 read-only zero
module rsd_regs #(
    parameter int CODE_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Factory one-time-programmable defaults
    input wire logic [7:0] otp_ldo_two_ctrl,
    input wire logic [7:0] otp_ldo_three_ctrl,
    input wire logic [7:0] otp_disch_one,
    input wire logic [7:0] otp_disch_two,
    input wire logic otp_valid,
    input wire logic ldo_two_sleep_pin_sel,
    input wire logic ldo_three_sleep_pin_sel,
    // Register port from the serial host
    input wire rsd_pkg::rsd_req_s req,
    input wire logic rd,
    output logic [7:0] rdata,
    // Pins and rail status
    input wire logic sleep_pin_one,
    input wire logic sleep_pin_two,
    input wire logic [1:0] ldo_pin_enable,
    input wire logic [7:0] rail_enabled,
    // Voltage codes
    input wire logic [CODE_W-1:0] ldo_two_normal_code,
    input wire logic [CODE_W-1:0] ldo_two_sleep_code,
    input wire logic [CODE_W-1:0] ldo_three_normal_code,
    input wire logic [CODE_W-1:0] ldo_three_sleep_code,
    // Rail controls
    output logic [CODE_W-1:0] ldo_two_code,
    output logic [CODE_W-1:0] ldo_three_code,
    output logic ldo_two_on,
    output logic ldo_three_on,
    output logic [15:0] discharge_codes
);
    // Timing seen by the host
    // Write lands in its register at the next edge
    // Read data stands for the one cycle after the read
    // Rail codes and enables follow one edge after the register
    // Sleep pin change reaches the code about five edges later
    // Factory load takes the first edge after reset; a host write in that cycle is lost

    // Reset word of both LDO control registers: select 00, reserved 110
    localparam logic [7:0] CTRL_RESET = {4'h0, rsd_pkg::RSVD_RESET, 1'b0};

    // Every flip-flop of the block; one word keeps reset and update in step
    typedef struct packed {
        // Host-visible registers and read data
        rsd_pkg::rsd_state_s regs;
        // Factory defaults still to be loaded
        logic otp_load;
        // Sleep pin synchronisers, newest sample in bit 0
        logic [2:0] sync_one;
        logic [2:0] sync_two;
        // Settled sleep pin levels
        logic pin_one;
        logic pin_two;
        // Registered rail controls
        logic [CODE_W-1:0] two_code;
        logic [CODE_W-1:0] three_code;
        logic two_on;
        logic three_on;
    } rsd_all_s;

    // Reset value; sync stages start high, the idle level of the pins
    // Control registers start at 0ch until the factory load
    localparam rsd_all_s ALL_RESET = '{
        regs: '{
            ldo_two_ctrl: CTRL_RESET,
            ldo_three_ctrl: CTRL_RESET,
            disch: 16'h0000,
            rdata: 8'h00
        },
        otp_load: 1'b1,
        sync_one: 3'h7,
        sync_two: 3'h7,
        pin_one: 1'b1,
        pin_two: 1'b1,
        two_code: '0,
        three_code: '0,
        two_on: 1'b0,
        three_on: 1'b0
    };

    // State word and its next value
    rsd_all_s st_r;
    rsd_all_s st_nxt;
    // Decoded register select and per-rail views of the state
    logic [3:0] addr_hit;
    logic [1:0] two_sel;
    logic [1:0] three_sel;
    logic two_pin;
    logic three_pin;
    logic two_soft_en;
    logic three_soft_en;

    // Sleep pin level picked by the factory choice
    // Straps are static, so no synchroniser is needed here
    function automatic logic pick_pin(input logic sel, input logic p1,
                                      input logic p2);
        pick_pin = (sel == rsd_pkg::SLEEP_PIN_TWO) ? p2 : p1;
    endfunction

    // Voltage code from select field and pin
    // Reserved codes 01 and 10 act as 00, the safer normal voltage
    function automatic logic [CODE_W-1:0] pick_code(input logic [1:0] sel,
        input logic pin, input logic [CODE_W-1:0] nrm,
        input logic [CODE_W-1:0] slp);
        if (sel == rsd_pkg::SLEEP_ON && !pin)
        begin
            pick_code = slp;
        end
        else
        begin
            pick_code = nrm;
        end
    endfunction

    // Synchroniser verdict: second and third stage agree
    // Three stages cost a cycle of latency but cut metastability
    function automatic logic settled(input logic [2:0] stages);
        settled = (stages[1] == stages[2]);
    endfunction

    // One-hot register select; unmapped addresses select nothing
    // Mapped offsets are fixed; widen here to add a register
    function automatic logic [3:0] reg_sel(input logic [7:0] addr);
        if (addr == rsd_pkg::LDO_TWO_CONTROL_ADDR)
        begin
            reg_sel = 4'h1;
        end
        else if (addr == rsd_pkg::LDO_THREE_CONTROL_ADDR)
        begin
            reg_sel = 4'h2;
        end
        else if (addr == rsd_pkg::DISCHARGE_CONTROL_ONE_ADDR)
        begin
            reg_sel = 4'h4;
        end
        else if (addr == rsd_pkg::DISCHARGE_CONTROL_TWO_ADDR)
        begin
            reg_sel = 4'h8;
        end
        else
        begin
            reg_sel = 4'h0;
        end
    endfunction

    // Same decode serves writes and reads
    assign addr_hit = reg_sel(req.addr);

    // Per-rail fields of the stored control registers
    assign two_sel = st_r.regs.ldo_two_ctrl[rsd_pkg::SLEEP_SEL_LSB +: 2];
    assign three_sel = st_r.regs.ldo_three_ctrl[rsd_pkg::SLEEP_SEL_LSB +: 2];
    assign two_soft_en = st_r.regs.ldo_two_ctrl[rsd_pkg::SOFT_EN_BIT];
    assign three_soft_en = st_r.regs.ldo_three_ctrl[rsd_pkg::SOFT_EN_BIT];

    // Settled level of the pin each rail is strapped to
    assign two_pin = pick_pin(ldo_two_sleep_pin_sel, st_r.pin_one,
        st_r.pin_two);
    assign three_pin = pick_pin(ldo_three_sleep_pin_sel, st_r.pin_one,
        st_r.pin_two);

    // Next state of every flip-flop
    always_comb
    begin
        st_nxt = st_r;

        // Sleep pins are asynchronous: shift, then take a level
        // only once it has stood two cycles, so a glitch is ignored
        st_nxt.sync_one = {st_r.sync_one[1:0], sleep_pin_one};
        st_nxt.sync_two = {st_r.sync_two[1:0], sleep_pin_two};
        if (settled(st_r.sync_one))
        begin
            st_nxt.pin_one = st_r.sync_one[2];
        end
        if (settled(st_r.sync_two))
        begin
            st_nxt.pin_two = st_r.sync_two[2];
        end

        // Factory load done at the first edge with valid defaults
        if (otp_valid)
        begin
            st_nxt.otp_load = 1'b0;
        end

        // Register contents; a host write in the load cycle is lost
        if (st_r.otp_load && otp_valid)
        begin
            // Control bits 7:6 read zero, so the defaults are masked too
            st_nxt.regs.ldo_two_ctrl =
                otp_ldo_two_ctrl & rsd_pkg::LDO_CTRL_WMASK;
            st_nxt.regs.ldo_three_ctrl =
                otp_ldo_three_ctrl & rsd_pkg::LDO_CTRL_WMASK;
            st_nxt.regs.disch = {otp_disch_two, otp_disch_one};
        end
        else if (req.wr)
        begin
            // Host writes; bits 7:6 of the control registers are dropped
            if (addr_hit[0])
            begin
                st_nxt.regs.ldo_two_ctrl =
                    req.wdata & rsd_pkg::LDO_CTRL_WMASK;
            end
            else if (addr_hit[1])
            begin
                st_nxt.regs.ldo_three_ctrl =
                    req.wdata & rsd_pkg::LDO_CTRL_WMASK;
            end
            else if (addr_hit[2])
            begin
                st_nxt.regs.disch[7:0] = req.wdata;
            end
            else if (addr_hit[3])
            begin
                st_nxt.regs.disch[15:8] = req.wdata;
            end
        end

        // Rail bit i owns pair 2i+1:2i of the discharge word
        // 0 to 3: buck rails one to four, register 40h
        // 4 and 5: buck rails five and six, register 41h
        // 6: load switch A; 7: ldo rail two
        // Clearing every cycle lets an enabled rail beat a write
        for (int i = 0; i < rsd_pkg::NUM_DISCH_RAILS; i++)
        begin
            if (rail_enabled[i])
            begin
                st_nxt.regs.disch[2*i +: 2] = rsd_pkg::DISCH_NONE;
            end
        end

        // Read data stands one cycle; unmapped addresses read zero
        st_nxt.regs.rdata = 8'h00;
        if (rd)
        begin
            if (addr_hit[0])
            begin
                st_nxt.regs.rdata = st_r.regs.ldo_two_ctrl;
            end
            else if (addr_hit[1])
            begin
                st_nxt.regs.rdata = st_r.regs.ldo_three_ctrl;
            end
            else if (addr_hit[2])
            begin
                st_nxt.regs.rdata = st_r.regs.disch[7:0];
            end
            else if (addr_hit[3])
            begin
                st_nxt.regs.rdata = st_r.regs.disch[15:8];
            end
        end

        // Rail codes follow the stored select field and settled pin
        st_nxt.two_code = pick_code(two_sel, two_pin, ldo_two_normal_code,
            ldo_two_sleep_code);
        st_nxt.three_code = pick_code(three_sel, three_pin,
            ldo_three_normal_code, ldo_three_sleep_code);

        // Soft enable low overrides every control pin
        // Pin enable is decoded on this clock, so it needs no sync
        st_nxt.two_on = two_soft_en && ldo_pin_enable[0];
        st_nxt.three_on = three_soft_en && ldo_pin_enable[1];
    end

    // One register for all state; reset loads constants only
    // A second reset in mid-run reloads the factory defaults
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ALL_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    // Read data is zero whenever no read was taken
    assign rdata = st_r.regs.rdata;
    assign ldo_two_code = st_r.two_code;
    assign ldo_three_code = st_r.three_code;
    assign ldo_two_on = st_r.two_on;
    assign ldo_three_on = st_r.three_on;
    // Codes pass to the analog selector as stored
    assign discharge_codes = st_r.regs.disch;
endmodule

// *** test/rsd_regs_chk.sv ***
module rsd_regs_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host port
    input wire rsd_pkg::rsd_req_s req,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Rails
    input wire logic [7:0] rail_enabled,
    input wire logic ldo_two_on,
    input wire logic ldo_three_on,
    input wire logic [15:0] discharge_codes
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    dclr_buck_a: assert property (
        rail_enabled[0] |=> discharge_codes[1:0] == 2'h0)
        else $error("buck one discharge kept");
    dclr_ldo_a: assert property (
        rail_enabled[7] |=> discharge_codes[15:14] == 2'h0)
        else $error("ldo two discharge kept");
    wr_one_a: assert property (
        req.wr && req.addr == 8'h40 && rail_enabled[3:0] == 4'h0
        |=> discharge_codes[7:0] == $past(req.wdata)) else $error("40 lost");
    wr_two_a: assert property (
        req.wr && req.addr == 8'h41 && rail_enabled[7:4] == 4'h0
        |=> discharge_codes[15:8] == $past(req.wdata)) else $error("41 lost");
    rd_idle_a: assert property (
        !rd |=> rdata == 8'h00) else $error("read data without read");
    rsvd_rd_a: assert property (
        rd && req.addr[7:1] == 7'h14 |=> rdata[7:6] == 2'h0)
        else $error("control bits 7:6 not zero");
    off_two_a: assert property (
        req.wr && req.addr == 8'h28 && !req.wdata[0] |-> ##2 !ldo_two_on)
        else $error("ldo two stayed on");
    off_three_a: assert property (
        req.wr && req.addr == 8'h29 && !req.wdata[0] |-> ##2 !ldo_three_on)
        else $error("ldo three stayed on");
endmodule

bind rsd_regs rsd_regs_chk rsd_regs_chk_inst (.mclk(mclk), .rst_n(rst_n),
    .req(req), .rd(rd), .rdata(rdata), .rail_enabled(rail_enabled),
    .ldo_two_on(ldo_two_on), .ldo_three_on(ldo_three_on),
    .discharge_codes(discharge_codes));

// *** test/rsd_host.sv ***
module rsd_host (
    // Clock and read data
    input wire logic mclk,
    input wire logic [7:0] rdata,
    // Request
    output rsd_pkg::rsd_req_s req,
    output logic rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '{1'b0, 8'h00, 8'h00};
    initial rd = 1'b0;
    // One transfer; callers keep select 00/11 and reserved 110
    task automatic xfer(input logic w, input logic [7:0] a, d,
        output logic [7:0] q);
        req = '{w, a, d};
        rd = !w;
        @(posedge mclk);
        #1;
        q = rdata;
        // Released bus shows inverted lines, not stale values
        req = '{1'b0, ~a, ~d};
        rd = 1'b0;
        @(posedge mclk);
        #1;
    endtask
endmodule

// *** test/rsd_regs_bench.sv ***
module rsd_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic slp1 = 1'b1;
    logic slp2 = 1'b1;
    logic [1:0] pin_en = 2'h3;
    logic [7:0] rail_en = 8'h00;
    logic [31:0] otp = 32'hcd0c55aa;
    logic [31:0] vc = 32'h44332211;
    logic [7:0] rdata, q, c2, c3;
    logic on2, on3;
    logic [15:0] disch;
    rsd_pkg::rsd_req_s req;
    logic rd;
    int fails = 0;
    int n_compared = 0;
    // Address, write data, read-back
    logic [23:0] rows [5] = '{24'h28fd3d, 24'h29cd0d, 24'h40e4e4,
        24'h411b1b, 24'h2a5500};
    always #2 mclk = ~mclk;
    rsd_host rsd_host_inst (.mclk(mclk), .rdata(rdata), .req(req), .rd(rd));
    rsd_regs rsd_regs_inst (.mclk(mclk), .rst_n(rst_n),
        .otp_ldo_two_ctrl(otp[31:24]), .otp_ldo_three_ctrl(otp[23:16]),
        .otp_disch_one(otp[15:8]), .otp_disch_two(otp[7:0]),
        .otp_valid(1'b1), .ldo_two_sleep_pin_sel(1'b0),
        .ldo_three_sleep_pin_sel(1'b1), .req(req), .rd(rd), .rdata(rdata),
        .sleep_pin_one(slp1), .sleep_pin_two(slp2), .ldo_pin_enable(pin_en),
        .rail_enabled(rail_en), .ldo_two_normal_code(vc[7:0]),
        .ldo_two_sleep_code(vc[15:8]), .ldo_three_normal_code(vc[23:16]),
        .ldo_three_sleep_code(vc[31:24]), .ldo_two_code(c2),
        .ldo_three_code(c3), .ldo_two_on(on2), .ldo_three_on(on3),
        .discharge_codes(disch));
    task cmp(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, d);
        rsd_host_inst.xfer(1'b1, a, d, q);
    endtask
    task rdc(input logic [7:0] a, e);
        rsd_host_inst.xfer(1'b0, a, 8'h00, q);
        cmp("read", {8'h00, e}, {8'h00, q});
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task conclude;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        tick(12);
        rst_n = 1'b1;
        tick(2);
        rdc(8'h28, 8'h0d);
        rdc(8'h41, 8'haa);
        foreach (rows[i])
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][7:0]);
        end
        // Sleep pin two must not move ldo two
        wr(8'h28, 8'h3d);
        wr(8'h29, 8'h3d);
        slp2 = 1'b0;
        tick(8);
        cmp("two code", 16'h11, {8'h00, c2});
        cmp("three code", 16'h44, {8'h00, c3});
        slp1 = 1'b0;
        tick(8);
        cmp("two code", 16'h22, {8'h00, c2});
        wr(8'h28, 8'h0d);
        tick(8);
        cmp("two code", 16'h11, {8'h00, c2});
        wr(8'h28, 8'h0c);
        wr(8'h29, 8'h0c);
        tick(2);
        cmp("ons", 16'h0, {14'h0, on3, on2});
        wr(8'h28, 8'h3d);
        tick(2);
        cmp("ons", 16'h1, {14'h0, on3, on2});
        // Each enabled rail clears only its own pair
        for (int i = 0; i < 8; i++)
        begin
            rail_en = 8'h01 << i;
            wr(8'h40, 8'hff);
            wr(8'h41, 8'hff);
            cmp("discharge", ~(16'h3 << 2 * i), disch);
        end
        rail_en = 8'h00;
        rst_n = 1'b0;
        tick(2);
        cmp("reset rdata", 16'h0, {8'h00, rdata});
        cmp("reset discharge", 16'h0000, disch);
        rst_n = 1'b1;
        tick(2);
        rdc(8'h29, 8'h0c);
        rdc(8'h40, 8'h55);
        conclude();
    end
endmodule
